// File: dv/gtc_far_model.sv
// far side model: clock pin, gate pin, oscillator, other timer overflow
// assumes bench requests change just after pclk rising edges
`default_nettype none
module gtc_far_model (
  input wire logic pclk,
  input wire logic clk_run,
  input wire logic gate_lvl,
  input wire logic ovf_req,
  output logic ext_clock_pin,
  output logic ext_gate_pin,
  output logic low_freq_internal_osc,
  output logic other_timer_overflow
);
  timeunit 1ns;
  timeprecision 100ps;
  int ck_cnt;
  int osc_cnt;
  initial begin
    ck_cnt = 0;
    osc_cnt = 0;
    ext_clock_pin = 1'b0;
    ext_gate_pin = 1'b0;
    low_freq_internal_osc = 1'b0;
    other_timer_overflow = 1'b0;
  end
  // pin clock period 10 pclk, stands low outside a run
  always @(posedge pclk) begin
    if (clk_run || ext_clock_pin) begin
      ck_cnt <= (ck_cnt == 4) ? 0 : ck_cnt + 1;
      if (ck_cnt == 4) begin
        ext_clock_pin <= ~ext_clock_pin;
      end
    end
  end
  // oscillator runs free, period 16 pclk
  always @(posedge pclk) begin
    osc_cnt <= (osc_cnt == 7) ? 0 : osc_cnt + 1;
    if (osc_cnt == 7) begin
      low_freq_internal_osc <= ~low_freq_internal_osc;
    end
  end
  // gate level and one-cycle overflow pulse
  always @(posedge pclk) begin
    ext_gate_pin <= gate_lvl;
    other_timer_overflow <= ovf_req;
  end
endmodule
`default_nettype wire

// File: dv/tb_gated_16bit_timer_control.sv
// bench for the gated timer: APB master, far side model, self checks
// assumes zero wait state APB slave as handed over
`default_nettype none
module tb_gated_16bit_timer_control;
  timeunit 1ns;
  timeprecision 100ps;
  import gtc_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err_seen;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic ecp, egp, lfo, oto, ovf_f, gev_f, gval, clk_run, gate_lvl, ovf_req;
  logic [15:0] c, c1;
  int num_errors = 0;
  int samples_checked = 0;
  gtc_timer dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .ext_clock_pin(ecp), .ext_gate_pin(egp),
    .low_freq_internal_osc(lfo), .other_timer_overflow(oto), .overflow_flag(ovf_f),
    .gate_event_flag(gev_f), .gate_level_status(gval));
  gtc_far_model far (.pclk(pclk), .clk_run(clk_run), .gate_lvl(gate_lvl),
    .ovf_req(ovf_req), .ext_clock_pin(ecp), .ext_gate_pin(egp),
    .low_freq_internal_osc(lfo), .other_timer_overflow(oto));
  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end
  task automatic finish_test();
    $display("checks %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic rng(input string nm, input int lo, input int hi, input logic [15:0] g);
    samples_checked++;
    if (((g >= lo) && (g <= hi)) !== 1'b1) begin
      num_errors++;
      $display("mismatch %s expected %0d..%0d seen %0d", nm, lo, hi, g);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h000000, d};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    r = prdata;
    err_seen = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic count_run(input logic [7:0] tc, input int n, input logic run);
    wr(OFF_COUNT_LOW_BYTE, 8'h00);
    wr(OFF_COUNT_HIGH_BYTE, 8'h00);
    wr(OFF_TIMER_CONTROL, tc);
    clk_run <= run;
    repeat (n) @(posedge pclk);
    clk_run <= 1'b0;
    wr(OFF_TIMER_CONTROL, tc & 8'hFE);
    apb(1'b0, OFF_COUNT_LOW_BYTE, 8'h00);
    c[7:0] = r[7:0];
    apb(1'b0, OFF_COUNT_HIGH_BYTE, 8'h00);
    c[15:8] = r[7:0];
  endtask
  task automatic gate_pulse(input int n);
    gate_lvl <= 1'b1;
    repeat (n) @(posedge pclk);
    gate_lvl <= 1'b0;
    repeat (10) @(posedge pclk);
  endtask
  task automatic ovf_pulse();
    ovf_req <= 1'b1;
    @(posedge pclk);
    ovf_req <= 1'b0;
    repeat (8) @(posedge pclk);
  endtask
  task automatic t_regs();
    apb(1'b0, OFF_TIMER_CONTROL, 8'h00);
    cmp("timer_control reset", 32'h0, r);
    apb(1'b0, OFF_GATE_CONTROL, 8'h00);
    cmp("gate_control reset", 32'h0, r & 32'hFB);
    wr(OFF_TIMER_CONTROL, 8'hFF);
    apb(1'b0, OFF_TIMER_CONTROL, 8'h00);
    cmp("timer_control unused", 32'hF5, r);
    wr(OFF_TIMER_CONTROL, 8'h00);
    wr(OFF_GATE_CONTROL, 8'hF7);
    apb(1'b0, OFF_GATE_CONTROL, 8'h00);
    cmp("gate_control unused", 32'hF1, r & 32'hFB);
    wr(OFF_GATE_CONTROL, 8'h00);
    apb(1'b0, 8'h14, 8'h00);
    cmp("unmapped error", 32'h1, {31'h0, err_seen});
    cmp("unmapped data", 32'h0, r);
    $display("test regs done");
  endtask
  task automatic t_clk();
    int d;
    for (int p = 0; p < 4; p++) begin
      d = 1 << p;
      count_run(8'(8'h41 | (p << 4)), 61, 1'b0);
      rng("pclk prescaled count", 64 / d - 2, 64 / d + 3, c);
    end
    count_run(8'h01, 61, 1'b0);
    rng("pclk div4 count", 14, 19, c);
    count_run(8'h85, 100, 1'b1);
    rng("pin count bypass", 9, 11, c);
    count_run(8'h81, 100, 1'b1);
    rng("pin count synced", 9, 11, c);
    count_run(8'hC5, 125, 1'b0);
    rng("osc count", 7, 9, c);
    $display("test clock sources done");
  endtask
  task automatic t_ovf();
    wr(OFF_COUNT_LOW_BYTE, 8'hFE);
    wr(OFF_COUNT_HIGH_BYTE, 8'hFF);
    wr(OFF_TIMER_CONTROL, 8'h41);
    repeat (4) @(posedge pclk);
    wr(OFF_TIMER_CONTROL, 8'h40);
    cmp("overflow flag set", 32'h1, {31'h0, ovf_f});
    apb(1'b0, OFF_COUNT_HIGH_BYTE, 8'h00);
    cmp("count high wrapped", 32'h0, r);
    wr(OFF_EVENT_FLAGS, 8'h01);
    cmp("overflow flag clear", 32'h0, {31'h0, ovf_f});
    $display("test rollover done");
  endtask
  task automatic t_gate();
    wr(OFF_GATE_CONTROL, 8'hC0);
    count_run(8'h41, 61, 1'b0);
    rng("gate low active high", 0, 0, c);
    wr(OFF_GATE_CONTROL, 8'h80);
    count_run(8'h41, 61, 1'b0);
    rng("gate low active low", 62, 67, c);
    wr(OFF_GATE_CONTROL, 8'h40);
    count_run(8'h41, 61, 1'b0);
    rng("gate disabled", 62, 67, c);
    gate_lvl <= 1'b1;
    repeat (8) @(posedge pclk);
    cmp("gate value high", 32'h1, {31'h0, gval});
    gate_lvl <= 1'b0;
    repeat (8) @(posedge pclk);
    cmp("gate value low", 32'h0, {31'h0, gval});
    $display("test gate done");
  endtask
  task automatic t_tog();
    wr(OFF_EVENT_FLAGS, 8'h03);
    cmp("gate event clear", 32'h0, {31'h0, gev_f});
    wr(OFF_TIMER_CONTROL, 8'h41);
    wr(OFF_GATE_CONTROL, 8'h61);
    gate_pulse(4);
    cmp("pin ignored", 32'h0, {31'h0, gval});
    ovf_pulse();
    cmp("toggle on overflow", 32'h1, {31'h0, gval});
    ovf_pulse();
    cmp("toggle back", 32'h0, {31'h0, gval});
    cmp("gate event set", 32'h1, {31'h0, gev_f});
    wr(OFF_GATE_CONTROL, 8'h60);
    gate_pulse(4);
    cmp("toggle on pin", 32'h1, {31'h0, gval});
    wr(OFF_GATE_CONTROL, 8'h40);
    wr(OFF_GATE_CONTROL, 8'h60);
    repeat (4) @(posedge pclk);
    cmp("toggle flop cleared", 32'h0, {31'h0, gval});
    gate_pulse(4);
    cmp("toggle on pin again", 32'h1, {31'h0, gval});
    wr(OFF_TIMER_CONTROL, 8'h00);
    repeat (4) @(posedge pclk);
    cmp("off clears gate flop", 32'h0, {31'h0, gval});
    $display("test toggle done");
  endtask
  task automatic t_pulse();
    wr(OFF_TIMER_CONTROL, 8'h41);
    wr(OFF_GATE_CONTROL, 8'hD8);
    wr(OFF_COUNT_LOW_BYTE, 8'h00);
    apb(1'b0, OFF_GATE_CONTROL, 8'h00);
    cmp("armed", 32'h1, {31'h0, r[GC_GO_BIT]});
    repeat (20) @(posedge pclk);
    gate_pulse(20);
    apb(1'b0, OFF_GATE_CONTROL, 8'h00);
    cmp("done by hardware", 32'h0, {31'h0, r[GC_GO_BIT]});
    apb(1'b0, OFF_COUNT_LOW_BYTE, 8'h00);
    c1 = {8'h00, r[7:0]};
    rng("pulse width count", 17, 23, c1);
    gate_pulse(20);
    apb(1'b0, OFF_COUNT_LOW_BYTE, 8'h00);
    cmp("second pulse ignored", {24'h0, c1[7:0]}, r);
    wr(OFF_TIMER_CONTROL, 8'h00);
    wr(OFF_GATE_CONTROL, 8'h00);
    $display("test single pulse done");
  endtask
  initial begin
    repeat (20000) @(posedge pclk);
    num_errors++;
    finish_test();
  end
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    clk_run = 1'b0;
    gate_lvl = 1'b0;
    ovf_req = 1'b0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_regs();
    t_clk();
    t_ovf();
    t_gate();
    t_tog();
    t_pulse();
    finish_test();
  end
endmodule
`default_nettype wire

// File: hw/gtc_sync.sv
// multi-flop level synchroniser for a vector of pin inputs
// assumes inputs asynchronous to pclk; each bit treated alone
`default_nettype none
module gtc_sync #(
  parameter int WIDTH = 3,
  parameter int STAGES = 2
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);
  logic [WIDTH-1:0] stage_r [STAGES];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < STAGES; i++) begin
        stage_r[i] <= '0;
      end
    end else begin
      stage_r[0] <= d;
      for (int i = 1; i < STAGES; i++) begin
        stage_r[i] <= stage_r[i-1];
      end
    end
  end

  assign q = stage_r[STAGES-1];
endmodule
`default_nettype wire

// File: hw/gtc_timer.sv
// gated 16-bit timer with clock select, prescaler and gate logic
// assumes APB master on pclk; pins are asynchronous to pclk
// How it works
// - two-bit field selects the counter clock
// - prescaler divides selected clock by 1,2,4,8
// - sync bit set bypasses the extra clock alignment stage
// - on bit counts; off stops, clears gate flop
// - gate enable acts only while timer on
// - gate enable clear counts every prescaled edge
// - polarity bit selects active gate level
// - toggle bit routes gate via flop; clear holds
// - toggle flop flips on gate source rising edge
// - single-pulse bit hands gate to acquisition logic
// - software sets go/done to arm capture
// - hardware clears go/done when capture completes
// - read-only bit shows current gate value
// - gate value tracks regardless of gate enable
// - source select picks gate pin or overflow
// - unimplemented control bits read as zero
// - reset clears writable control bits to zero
// - count wraps all ones to zero, sets flag
// - gate value falling edge sets gate event flag
// - trailing edge ends pulse; ignore until rearmed
// - counter increments on selected clock rising edge
//
// The implementer's own choices: the address map and the APB interface to the registers.
`default_nettype none
module gtc_timer
  import gtc_pkg::*;
#(
  parameter int ADDR_W = 8,
  parameter int CNT_W = 16
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic ext_clock_pin,
  input wire logic ext_gate_pin,
  input wire logic low_freq_internal_osc,
  input wire logic other_timer_overflow,
  output logic overflow_flag,
  output logic gate_event_flag,
  output logic gate_level_status
);
  logic [7:0] tc_r;
  logic [7:0] gc_r;
  logic [CNT_W-1:0] cnt_r;
  logic [CNT_W-1:0] cnt_nxt;
  logic ovf_r;
  logic gev_r;
  logic [31:0] prdata_r;
  logic [31:0] rdata;
  logic [2:0] pins_s;
  logic [1:0] clk_rs_r;
  logic [1:0] clk_prev_r;
  logic [1:0] clk_lvl;
  logic [1:0] div_r;
  logic [2:0] ps_cnt_r;
  logic [2:0] ps_lim;
  logic src_tick;
  logic presc_tick;
  logic gsrc;
  logic gsrc_q_r;
  logic tgl_r;
  logic gate_t;
  logic gate_act;
  logic gate_act_q_r;
  logic gate_val;
  logic gval_r;
  gtc_sp_type sp_r;
  logic wr;
  logic rd_setup;
  logic cnt_wr;
  logic cnt_en;
  logic go_wr;
  logic on;

  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [7:0] off);
    return a == ADDR_W'(off);
  endfunction

  function automatic logic mapped(input logic [ADDR_W-1:0] a);
    return hit(a, OFF_TIMER_CONTROL) | hit(a, OFF_GATE_CONTROL) |
      hit(a, OFF_COUNT_LOW_BYTE) | hit(a, OFF_COUNT_HIGH_BYTE) |
      hit(a, OFF_EVENT_FLAGS);
  endfunction

  function automatic logic [2:0] ratio_lim(input logic [1:0] code);
    case (code)
      2'h0: return 3'h0;
      2'h1: return 3'h1;
      2'h2: return 3'h3;
      default: return 3'h7;
    endcase
  endfunction

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  // apb slave, zero wait states
  assign wr = psel & penable & pwrite & pstrb[0];
  assign rd_setup = psel & ~penable;
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~mapped(paddr);
  assign prdata = prdata_r;
  assign on = tc_r[TC_ON_BIT];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tc_r <= TC_RST;
      gc_r <= GC_RST;
    end else begin
      if (wr && hit(paddr, OFF_TIMER_CONTROL)) begin
        tc_r <= pwdata[7:0] & TC_WMASK;
      end
      if (wr && hit(paddr, OFF_GATE_CONTROL)) begin
        gc_r <= pwdata[7:0] & GC_WMASK;
      end
    end
  end

  // read mux with live gate value
  always_comb begin
    rdata = 32'h0000_0000;
    if (hit(paddr, OFF_TIMER_CONTROL)) begin
      rdata[7:0] = tc_r & TC_WMASK;
    end else if (hit(paddr, OFF_GATE_CONTROL)) begin
      rdata[7:0] = gc_r & GC_WMASK;
      rdata[GC_GO_BIT] = (sp_r != SP_IDLE);
      rdata[GC_VAL_BIT] = gval_r;
    end else if (hit(paddr, OFF_COUNT_LOW_BYTE)) begin
      rdata[7:0] = cnt_r[7:0];
    end else if (hit(paddr, OFF_COUNT_HIGH_BYTE)) begin
      rdata[7:0] = cnt_r[15:8];
    end else if (hit(paddr, OFF_EVENT_FLAGS)) begin
      rdata[EF_OVF_BIT] = ovf_r;
      rdata[EF_GEV_BIT] = gev_r;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= 32'h0000_0000;
    end else if (rd_setup && !pwrite) begin
      prdata_r <= rdata;
    end
  end

  // pin synchroniser: clock pin, gate pin, low-frequency oscillator
  gtc_sync #(
    .WIDTH(3),
    .STAGES(2)
  ) u_pin_sync (
    .pclk(pclk),
    .presetn(presetn),
    .d({low_freq_internal_osc, ext_gate_pin, ext_clock_pin}),
    .q(pins_s)
  );

  // extra stage aligns clock inputs to system clock
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clk_rs_r <= 2'h0;
      clk_prev_r <= 2'h0;
    end else begin
      clk_rs_r <= {pins_s[2], pins_s[0]};
      clk_prev_r <= clk_lvl;
    end
  end

  assign clk_lvl = tc_r[TC_SYNC_BIT] ? {pins_s[2], pins_s[0]} : clk_rs_r;

  // instruction clock phase counter
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_r <= 2'h0;
    end else begin
      div_r <= div_r + 2'h1;
    end
  end

  always_comb begin
    case (tc_r[TC_CS_MSB:TC_CS_LSB])
      CS_LFOSC: src_tick = clk_lvl[1] & ~clk_prev_r[1];
      CS_PIN: src_tick = clk_lvl[0] & ~clk_prev_r[0];
      CS_FOSC: src_tick = 1'b1;
      CS_FOSC4: src_tick = (div_r == DIV4_LAST);
      default: src_tick = 1'b0;
    endcase
  end

  assign ps_lim = ratio_lim(tc_r[TC_PS_MSB:TC_PS_LSB]);
  assign presc_tick = src_tick & (ps_cnt_r >= ps_lim);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ps_cnt_r <= 3'h0;
    end else if (!on || presc_tick) begin
      ps_cnt_r <= 3'h0;
    end else if (src_tick) begin
      ps_cnt_r <= ps_cnt_r + 3'h1;
    end
  end

  assign gsrc = gc_r[GC_GSS_BIT] ? other_timer_overflow : pins_s[1];

  // toggle flop held clear when mode off
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tgl_r <= 1'b0;
      gsrc_q_r <= 1'b0;
    end else begin
      gsrc_q_r <= gsrc;
      if (!gc_r[GC_TM_BIT] || !on) begin
        tgl_r <= 1'b0;
      end else if (gsrc && !gsrc_q_r) begin
        tgl_r <= ~tgl_r;
      end
    end
  end

  assign gate_t = gc_r[GC_TM_BIT] ? tgl_r : gsrc;
  assign gate_act = gc_r[GC_POL_BIT] ? gate_t : ~gate_t;

  assign go_wr = wr && hit(paddr, OFF_GATE_CONTROL);

  // single-pulse acquisition state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sp_r <= SP_IDLE;
      gate_act_q_r <= 1'b0;
    end else begin
      gate_act_q_r <= gate_act;
      if (go_wr) begin
        sp_r <= pwdata[GC_GO_BIT] ? SP_ARMED : SP_IDLE;
      end else if (gc_r[GC_SPM_BIT] && on) begin
        case (sp_r)
          SP_IDLE: sp_r <= SP_IDLE;
          SP_ARMED: begin
            if (gate_act && !gate_act_q_r) begin
              sp_r <= SP_OPEN;
            end
          end
          SP_OPEN: begin
            if (!gate_act) begin
              sp_r <= SP_IDLE;
            end
          end
          default: sp_r <= SP_IDLE;
        endcase
      end
    end
  end

  assign gate_val = gc_r[GC_SPM_BIT] ? (gate_act && sp_r == SP_OPEN) : gate_act;

  // gate value sampled regardless of enable
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gval_r <= 1'b0;
    end else begin
      gval_r <= gate_val;
    end
  end

  assign gate_level_status = gval_r;

  assign cnt_en = on & presc_tick & (~gc_r[GC_GE_BIT] | gval_r);
  assign cnt_wr = wr & (hit(paddr, OFF_COUNT_LOW_BYTE) | hit(paddr, OFF_COUNT_HIGH_BYTE));

  always_comb begin
    cnt_nxt = cnt_r;
    if (wr && hit(paddr, OFF_COUNT_LOW_BYTE)) begin
      cnt_nxt[7:0] = pwdata[7:0];
    end else if (wr && hit(paddr, OFF_COUNT_HIGH_BYTE)) begin
      cnt_nxt[15:8] = pwdata[7:0];
    end else if (cnt_en) begin
      cnt_nxt = CNT_W'(cnt_r + CNT_W'(1));
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r <= CNT_RST;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

  // rollover sets overflow flag, set wins
  // gate value fall sets event flag
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ovf_r <= 1'b0;
      gev_r <= 1'b0;
    end else begin
      if (cnt_en && !cnt_wr && cnt_r == CNT_MAX) begin
        ovf_r <= 1'b1;
      end else if (wr && hit(paddr, OFF_EVENT_FLAGS) && pwdata[EF_OVF_BIT]) begin
        ovf_r <= 1'b0;
      end
      if (gval_r && !gate_val) begin
        gev_r <= 1'b1;
      end else if (wr && hit(paddr, OFF_EVENT_FLAGS) && pwdata[EF_GEV_BIT]) begin
        gev_r <= 1'b0;
      end
    end
  end

  assign overflow_flag = ovf_r;
  assign gate_event_flag = gev_r;

  sequence s_pulse_lead;
    sp_r == SP_ARMED && gate_act && !gate_act_q_r && !go_wr &&
      gc_r[GC_SPM_BIT] && on;
  endsequence

  sequence s_pulse_trail;
    sp_r == SP_OPEN && !gate_act && !go_wr && gc_r[GC_SPM_BIT] && on;
  endsequence

  chk_off_holds: assert property (
    !on && !cnt_wr |=> $stable(cnt_r)
  ) else $error("count moved while timer off");

  chk_off_gate: assert property (
    !on |=> !tgl_r
  ) else $error("gate flop not cleared while off");

  chk_free_count: assert property (
    on && !gc_r[GC_GE_BIT] && presc_tick && !cnt_wr |=>
      cnt_r == CNT_W'($past(cnt_r) + CNT_W'(1))
  ) else $error("free-running count missed an edge");

  chk_gate_hold: assert property (
    on && gc_r[GC_GE_BIT] && !gval_r && !cnt_wr |=> $stable(cnt_r)
  ) else $error("count moved with gate inactive");

  chk_toggle_clear: assert property (
    !gc_r[GC_TM_BIT] |=> !tgl_r
  ) else $error("toggle flop not held clear");

  chk_toggle_flip: assert property (
    gc_r[GC_TM_BIT] && on && gsrc && !gsrc_q_r |=> tgl_r != $past(tgl_r)
  ) else $error("toggle flop missed a rising edge");

  chk_pulse_open: assert property (
    s_pulse_lead |=> sp_r == SP_OPEN
  ) else $error("armed capture missed the leading edge");

  chk_pulse_done: assert property (
    s_pulse_trail |=> sp_r == SP_IDLE
  ) else $error("go/done not cleared at trailing edge");

  chk_pulse_idle: assert property (
    sp_r == SP_IDLE && gc_r[GC_SPM_BIT] && !go_wr |=> !gval_r
  ) else $error("gate passed events while not armed");

  chk_rsvd_zero: assert property (
    rd_setup && !pwrite && hit(paddr, OFF_TIMER_CONTROL) |=>
      prdata[3] == 1'b0 && prdata[1] == 1'b0 && prdata[31:8] == 24'h000000
  ) else $error("reserved control bits read non-zero");

  chk_wrap_flag: assert property (
    cnt_en && !cnt_wr && cnt_r == CNT_MAX |=> cnt_r == CNT_RST && ovf_r
  ) else $error("rollover did not wrap or flag");

  chk_gate_event: assert property (
    gval_r && !gate_val |=> gev_r
  ) else $error("gate event flag not set on fall");

  chk_status_track: assert property (
    gc_r[GC_GE_BIT] == 1'b0 && $changed(gate_val) |=> gval_r == $past(gate_val)
  ) else $error("gate value status stopped tracking");
endmodule
`default_nettype wire

// File: shared/gtc_pkg.sv
// constants and types of the gated 16-bit timer control block
// assumes an APB slave with 32-bit data, one aligned word per register
`default_nettype none
package gtc_pkg;
  // register byte offsets
  localparam logic [7:0] OFF_TIMER_CONTROL = 8'h00;
  localparam logic [7:0] OFF_GATE_CONTROL = 8'h04;
  localparam logic [7:0] OFF_COUNT_LOW_BYTE = 8'h08;
  localparam logic [7:0] OFF_COUNT_HIGH_BYTE = 8'h0C;
  localparam logic [7:0] OFF_EVENT_FLAGS = 8'h10;
  // timer_control fields
  localparam int TC_CS_MSB = 7;
  localparam int TC_CS_LSB = 6;
  localparam int TC_PS_MSB = 5;
  localparam int TC_PS_LSB = 4;
  localparam int TC_SYNC_BIT = 2;
  localparam int TC_ON_BIT = 0;
  localparam logic [7:0] TC_WMASK = 8'hF5;
  localparam logic [7:0] TC_RST = 8'h00;
  // gate_control fields
  localparam int GC_GE_BIT = 7;
  localparam int GC_POL_BIT = 6;
  localparam int GC_TM_BIT = 5;
  localparam int GC_SPM_BIT = 4;
  localparam int GC_GO_BIT = 3;
  localparam int GC_VAL_BIT = 2;
  localparam int GC_GSS_BIT = 0;
  localparam logic [7:0] GC_WMASK = 8'hF1;
  localparam logic [7:0] GC_RST = 8'h00;
  // event_flags fields, write one to clear
  localparam int EF_OVF_BIT = 0;
  localparam int EF_GEV_BIT = 1;
  // clock source codes
  localparam logic [1:0] CS_LFOSC = 2'h3;
  localparam logic [1:0] CS_PIN = 2'h2;
  localparam logic [1:0] CS_FOSC = 2'h1;
  localparam logic [1:0] CS_FOSC4 = 2'h0;
  // instruction clock divider, last phase of four
  localparam logic [1:0] DIV4_LAST = 2'h3;
  // count rollover
  localparam logic [15:0] CNT_MAX = 16'hFFFF;
  localparam logic [15:0] CNT_RST = 16'h0000;
  // single-pulse acquisition states
  typedef enum logic [1:0] {
    SP_IDLE,
    SP_ARMED,
    SP_OPEN
  } gtc_sp_type;
endpackage
`default_nettype wire
